// ==== can_bus_model.sv ====
// far-side model: protocol engine and bus events seen by the init block
`timescale 1ns/100ps
module can_bus_model (
	input  wire logic clk_i,
	output logic       can_tx_o,
	output logic       bus_idle_o,
	output logic       bus_activity_o,
	output logic       rx_fg_loaded_o,
	output logic       rx_overrun_o,
	output logic [2:0] tx_buffer_empty_o,
	output logic [2:0] tx_aborted_o,
	output logic [8:0] tx_err_cnt_o,
	output logic [8:0] rx_err_cnt_o
);
	initial begin
		{can_tx_o, bus_idle_o} = 2'h3;
		{tx_aborted_o, bus_activity_o, rx_fg_loaded_o, rx_overrun_o} = 6'h00;
		tx_buffer_empty_o = 3'h7;
		{tx_err_cnt_o, rx_err_cnt_o} = 18'h00000;
	end
	// one-cycle events: [5:3] abort done, [2] bus activity, [1] foreground load, [0] overrun
	task automatic pulse(input logic [5:0] ev);
		@(negedge clk_i);
		{tx_aborted_o, bus_activity_o, rx_fg_loaded_o, rx_overrun_o} = ev;
		@(negedge clk_i);
		{tx_aborted_o, bus_activity_o, rx_fg_loaded_o, rx_overrun_o} = 6'h00;
	endtask
	// a frame in progress holds a dominant bit and a busy bus
	task automatic frame(input logic on);
		@(negedge clk_i);
		can_tx_o = ~on;
		bus_idle_o = ~on;
	endtask
	task automatic levels(input logic [2:0] empty, input logic [8:0] tx, input logic [8:0] rx);
		@(negedge clk_i);
		tx_buffer_empty_o = empty;
		tx_err_cnt_o = tx;
		rx_err_cnt_o = rx;
	endtask
endmodule

// ==== can_init_cfg.svh ====
// constants for the can init-mode and interrupt block
// How it works
// - entering init aborts any frame in progress and drops bus synchronisation
// - entering init forces the can transmit pin recessive at once
// - in init the protocol engine stops; host-side registers stay accessible
// - init returns control, flag, enable, abort and buffer-select registers to defaults
// - bit-timing, acceptance control and filter registers are writable during init
// - init request crosses every internal domain through a synchronising handshake
// - entry into init takes at least two bus plus three can clocks
// - init ack sets only when all domains are in init
// - clearing init request is ignored until request and ack are both set
// - four interrupt outputs, each locally enabled and gated by the cpu mask
// - error irq combines status change and overrun; tx irq combines three empties
// - an empty loadable transmit buffer sets its empty flag
// - a message moved into the foreground buffer sets rx full
// - each further fifo message moved to the foreground sets rx full again
// - bus activity during sleep with wakeup enabled sets the wakeup flag
// - receive fifo overrun sets the overrun flag
// - error counters entering warning, passive or bus-off set status change
// - tx and rx state fields report the bus state behind status change
`ifndef CAN_INIT_CFG_SVH
`define CAN_INIT_CFG_SVH
`define BUS_SYNC_STAGES   2
`define CAN_SYNC_STAGES   3
`define ACK_SYNC_STAGES   2
`define CAN_RECESSIVE     1'h1
`define TX_EMPTY_RESET    3'h7
`define CFG_REGS          19
`define CFG_INDEX_W       5
`define RX_BIT_RXFULL     0
`define RX_BIT_OVERRUN    1
`define RX_BIT_STATUS     2
`define RX_BIT_WAKEUP     3
`define ERR_WARN_LIMIT    9'h060
`define ERR_PASSIVE_LIMIT 9'h080
`define ERR_BUSOFF_LIMIT  9'h100
`define BUS_STATE_OK      2'h0
`define BUS_STATE_WARN    2'h1
`define BUS_STATE_PASSIVE 2'h2
`define BUS_STATE_BUSOFF  2'h3
`endif

// ==== can_init_ctrl.sv ====
// init-mode handshake, register defaults and interrupt logic of the can controller
`timescale 1ns/100ps
`include "can_init_cfg.svh"
module can_init_ctrl
	import can_init_pkg::*;
(
	input  wire logic                         clk_i,
	input  wire logic                         rst_n_i,
	input  wire logic                         ctl0_wr_i,
	input  wire logic                         ctl0_init_request_i,
	input  wire logic                         ctl0_sleep_request_i,
	input  wire logic                         ctl0_wakeup_enable_i,
	input  wire logic                         rx_ie_wr_i,
	input  wire logic [3:0]                   rx_ie_data_i,
	input  wire logic                         tx_ie_wr_i,
	input  wire logic [2:0]                   tx_ie_data_i,
	input  wire logic [3:0]                   rx_flag_clear_i,
	input  wire logic [2:0]                   tx_flag_clear_i,
	input  wire logic                         tx_ctl_wr_i,
	input  wire logic [2:0]                   tx_abort_request_data_i,
	input  wire logic [2:0]                   tx_buffer_select_data_i,
	input  wire logic                         cfg_wr_i,
	input  wire logic [`CFG_INDEX_W-1:0]      cfg_index_i,
	input  wire logic [7:0]                   cfg_data_i,
	input  wire logic                         cpu_int_mask_i,
	input  wire logic                         can_tx_i,
	input  wire logic                         bus_idle_i,
	input  wire logic                         bus_activity_i,
	input  wire logic                         rx_fg_loaded_i,
	input  wire logic                         rx_overrun_i,
	input  wire logic [2:0]                   tx_buffer_empty_i,
	input  wire logic [2:0]                   tx_aborted_i,
	input  wire logic [8:0]                   tx_err_cnt_i,
	input  wire logic [8:0]                   rx_err_cnt_i,
	output logic                              can_tx_pin_o,
	output logic                              engine_stop_o,
	output logic                              abort_o,
	output logic                              init_request_o,
	output logic                              init_ack_o,
	output logic                              sleep_ack_o,
	output logic [3:0]                        rx_flags_o,
	output logic [2:0]                        tx_empty_flags_o,
	output logic [1:0]                        tx_state_field_o,
	output logic [1:0]                        rx_state_field_o,
	output logic [2:0]                        tx_abort_request_o,
	output logic [2:0]                        tx_abort_ack_o,
	output logic [2:0]                        tx_buffer_select_o,
	output logic [`CFG_REGS*8-1:0]            cfg_o,
	output logic                              irq_wakeup_o,
	output logic                              irq_error_o,
	output logic                              irq_rx_o,
	output logic                              irq_tx_o
);

	////////////////////////////////////////////////////////////////////////////////
	function automatic state_t reset_state();
		state_t s;
		s                = '0;
		s.fsm            = RUN_ST;
		s.tx_empty_flags = `TX_EMPTY_RESET;
		s.can_tx         = `CAN_RECESSIVE;
		return s;
	endfunction

	localparam state_t ST_RESET = reset_state();

	function automatic logic [1:0] bus_state(input logic [8:0] cnt, input logic tx);
		if (tx && cnt >= `ERR_BUSOFF_LIMIT)
			return `BUS_STATE_BUSOFF;
		else if (cnt >= `ERR_PASSIVE_LIMIT)
			return `BUS_STATE_PASSIVE;
		else if (cnt >= `ERR_WARN_LIMIT)
			return `BUS_STATE_WARN;
		return `BUS_STATE_OK;
	endfunction

	state_t st_q;
	state_t st_d;
	logic   can_init;

	// can-side view of the request after its synchroniser
	assign can_init = st_q.can_sync[`CAN_SYNC_STAGES-1];

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_d = st_q;

		// request travels bus stages, can stages, then back as ack
		st_d.bus_sync = {st_q.bus_sync[`BUS_SYNC_STAGES-2:0], st_q.init_request};
		st_d.can_sync = {st_q.can_sync[`CAN_SYNC_STAGES-2:0], st_q.bus_sync[`BUS_SYNC_STAGES-1]};
		st_d.ack_sync = {st_q.ack_sync[`ACK_SYNC_STAGES-2:0], can_init};

		unique case (st_q.fsm)
			RUN_ST: begin
				if (st_q.init_request)
					st_d.fsm = ENTER_ST;
			end
			ENTER_ST: begin
				if (st_q.ack_sync[`ACK_SYNC_STAGES-1])
					st_d.fsm = INIT_ST;
			end
			INIT_ST: begin
				if (!st_q.init_request)
					st_d.fsm = LEAVE_ST;
			end
			LEAVE_ST: begin
				if (!st_q.ack_sync[`ACK_SYNC_STAGES-1])
					st_d.fsm = RUN_ST;
			end
		endcase
		// ack holds through the leave handshake and drops only once the can side has left
		st_d.init_ack = (st_d.fsm == INIT_ST) || (st_d.fsm == LEAVE_ST);

		// control register 0 writes; a clear before ack is dropped
		if (ctl0_wr_i) begin
			st_d.sleep_request = ctl0_sleep_request_i;
			st_d.wakeup_enable = ctl0_wakeup_enable_i;
			if (ctl0_init_request_i)
				st_d.init_request = 1'b1;
			else if (st_q.init_request && st_q.init_ack)
				st_d.init_request = 1'b0;
		end
		st_d.sleep_ack = st_d.sleep_request && (st_q.sleep_ack || bus_idle_i) && !can_init;

		if (rx_ie_wr_i)
			st_d.rx_ie = rx_ie_data_i;
		if (tx_ie_wr_i)
			st_d.tx_empty_ie = tx_ie_data_i;
		if (tx_ctl_wr_i) begin
			st_d.tx_abort_request = st_q.tx_abort_request | tx_abort_request_data_i;
			st_d.tx_buffer_select = tx_buffer_select_data_i;
		end
		st_d.tx_abort_ack     = st_q.tx_abort_ack | tx_aborted_i;
		st_d.tx_abort_request = st_d.tx_abort_request & ~tx_aborted_i;

		// flags: a set in the same cycle as a clear wins
		st_d.rx_flags = st_q.rx_flags & ~rx_flag_clear_i;
		if (rx_fg_loaded_i)
			st_d.rx_flags[`RX_BIT_RXFULL] = 1'b1;
		if (rx_overrun_i)
			st_d.rx_flags[`RX_BIT_OVERRUN] = 1'b1;
		if (st_q.sleep_ack && st_q.wakeup_enable && bus_activity_i)
			st_d.rx_flags[`RX_BIT_WAKEUP] = 1'b1;
		st_d.tx_empty_flags = (st_q.tx_empty_flags & ~tx_flag_clear_i) | tx_buffer_empty_i;

		// bus state from the error counters
		st_d.tx_state = bus_state(tx_err_cnt_i, 1'b1);
		st_d.rx_state = bus_state(rx_err_cnt_i, 1'b0);
		if (st_d.tx_state != st_q.tx_state || st_d.rx_state != st_q.rx_state)
			st_d.rx_flags[`RX_BIT_STATUS] = 1'b1;

		// configuration only while init is acknowledged
		if (cfg_wr_i && st_q.init_ack && cfg_index_i < `CFG_INDEX_W'(`CFG_REGS))
			st_d.cfg[cfg_index_i] = cfg_data_i;

		// can side: stop engine, drop the frame, pin recessive
		st_d.engine_stop = can_init;
		st_d.abort       = can_init && !st_q.engine_stop;
		st_d.can_tx      = can_init ? `CAN_RECESSIVE : can_tx_i;
		if (can_init) begin
			st_d.sleep_request    = ST_RESET.sleep_request;
			st_d.sleep_ack        = ST_RESET.sleep_ack;
			st_d.wakeup_enable    = ST_RESET.wakeup_enable;
			st_d.rx_flags         = ST_RESET.rx_flags;
			st_d.rx_ie            = ST_RESET.rx_ie;
			st_d.tx_empty_flags   = ST_RESET.tx_empty_flags;
			st_d.tx_empty_ie      = ST_RESET.tx_empty_ie;
			st_d.tx_abort_request = ST_RESET.tx_abort_request;
			st_d.tx_abort_ack     = ST_RESET.tx_abort_ack;
			st_d.tx_buffer_select = ST_RESET.tx_buffer_select;
		end

		// interrupt lines from the registered flags and enables
		st_d.irq[3] = st_q.rx_flags[`RX_BIT_WAKEUP] && st_q.rx_ie[`RX_BIT_WAKEUP] && !cpu_int_mask_i;
		st_d.irq[2] = ((st_q.rx_flags[`RX_BIT_STATUS] && st_q.rx_ie[`RX_BIT_STATUS])
			|| (st_q.rx_flags[`RX_BIT_OVERRUN] && st_q.rx_ie[`RX_BIT_OVERRUN])) && !cpu_int_mask_i;
		st_d.irq[1] = st_q.rx_flags[`RX_BIT_RXFULL] && st_q.rx_ie[`RX_BIT_RXFULL] && !cpu_int_mask_i;
		st_d.irq[0] = (|(st_q.tx_empty_flags & st_q.tx_empty_ie)) && !cpu_int_mask_i;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			st_q <= ST_RESET;
		else
			st_q <= st_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	assign can_tx_pin_o       = st_q.can_tx;
	assign engine_stop_o      = st_q.engine_stop;
	assign abort_o            = st_q.abort;
	assign init_request_o     = st_q.init_request;
	assign init_ack_o         = st_q.init_ack;
	assign sleep_ack_o        = st_q.sleep_ack;
	assign rx_flags_o         = st_q.rx_flags;
	assign tx_empty_flags_o   = st_q.tx_empty_flags;
	assign tx_state_field_o   = st_q.tx_state;
	assign rx_state_field_o   = st_q.rx_state;
	assign tx_abort_request_o = st_q.tx_abort_request;
	assign tx_abort_ack_o     = st_q.tx_abort_ack;
	assign tx_buffer_select_o = st_q.tx_buffer_select;
	assign cfg_o              = st_q.cfg;
	assign irq_wakeup_o       = st_q.irq[3];
	assign irq_error_o        = st_q.irq[2];
	assign irq_rx_o           = st_q.irq[1];
	assign irq_tx_o           = st_q.irq[0];

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_tx_recessive;
		can_init |=> can_tx_pin_o;
	endproperty
	a_tx_recessive: assert property (p_tx_recessive) else $error("tx pin not recessive in init");

	property p_abort;
		$rose(can_init) |=> abort_o ##1 !abort_o;
	endproperty
	a_abort: assert property (p_abort) else $error("abort pulse missing on init entry");

	property p_stop;
		can_init |=> engine_stop_o;
	endproperty
	a_stop: assert property (p_stop) else $error("engine not stopped in init");

	property p_defaults;
		can_init && !ctl0_wr_i |=> tx_empty_flags_o == `TX_EMPTY_RESET && rx_flags_o == 4'h0
			&& tx_abort_request_o == 3'h0 && !sleep_ack_o;
	endproperty
	a_defaults: assert property (p_defaults) else $error("registers not at defaults in init");

	property p_min_delay;
		$rose(init_request_o) |-> !init_ack_o [*6];
	endproperty
	a_min_delay: assert property (p_min_delay) else $error("init ack came too early");

	property p_ack_all;
		$rose(init_ack_o) |-> can_init && engine_stop_o;
	endproperty
	a_ack_all: assert property (p_ack_all) else $error("init ack before can side in init");

	property p_no_clear;
		init_request_o && !init_ack_o |=> init_request_o;
	endproperty
	a_no_clear: assert property (p_no_clear) else $error("init request cleared before ack");

	property p_irq_tx;
		irq_tx_o |-> $past(|(tx_empty_flags_o & st_q.tx_empty_ie)) && !$past(cpu_int_mask_i);
	endproperty
	a_irq_tx: assert property (p_irq_tx) else $error("tx irq without enabled empty flag");

	property p_irq_mask;
		cpu_int_mask_i |=> !irq_tx_o && !irq_rx_o && !irq_error_o && !irq_wakeup_o;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq raised under cpu mask");

	property p_rxfull;
		rx_fg_loaded_i && !can_init |=> rx_flags_o[`RX_BIT_RXFULL];
	endproperty
	a_rxfull: assert property (p_rxfull) else $error("rx full not set");

	property p_overrun;
		rx_overrun_i && !can_init |=> rx_flags_o[`RX_BIT_OVERRUN];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun flag not set");

	property p_wakeup;
		sleep_ack_o && st_q.wakeup_enable && bus_activity_i && !can_init |=> rx_flags_o[`RX_BIT_WAKEUP];
	endproperty
	a_wakeup: assert property (p_wakeup) else $error("wakeup flag not set");

	property p_status;
		($changed(tx_state_field_o) || $changed(rx_state_field_o)) && !$past(can_init)
			|-> rx_flags_o[`RX_BIT_STATUS];
	endproperty
	a_status: assert property (p_status) else $error("status change flag not set");

	property p_leave;
		$fell(init_ack_o) |-> !can_init && !init_request_o;
	endproperty
	a_leave: assert property (p_leave) else $error("init ack fell before can side left");

	property p_sync_chain;
		$rose(can_init) |-> $past(init_request_o, `BUS_SYNC_STAGES + `CAN_SYNC_STAGES);
	endproperty
	a_sync_chain: assert property (p_sync_chain) else $error("can side entered init without request");

	property p_leave_sync;
		$fell(init_ack_o) |-> !$past(can_init, `ACK_SYNC_STAGES + 1);
	endproperty
	a_leave_sync: assert property (p_leave_sync) else $error("init ack fell before handshake back");

	property p_tx_empty;
		tx_buffer_empty_i != 3'h0 |=> (tx_empty_flags_o & $past(tx_buffer_empty_i)) == $past(tx_buffer_empty_i);
	endproperty
	a_tx_empty: assert property (p_tx_empty) else $error("empty buffer without its flag");

	property p_irq_rx;
		irq_rx_o |-> $past(rx_flags_o[`RX_BIT_RXFULL]) && !$past(cpu_int_mask_i);
	endproperty
	a_irq_rx: assert property (p_irq_rx) else $error("rx irq without rx full flag");

	c_enter: cover property ($rose(init_ack_o));
	c_leave: cover property ($fell(init_ack_o));
	c_irq_err: cover property (irq_error_o);
	c_wake: cover property ($rose(irq_wakeup_o));
	c_irq_tx: cover property ($rose(irq_tx_o));

endmodule

// ==== can_init_ctrl_tb_top.sv ====
// self-checking bench for the can init-mode and interrupt block
`timescale 1ns/100ps
`include "can_init_cfg.svh"
module can_init_ctrl_tb_top;
	logic clk_i, rst_n_i, ctl0_wr_i, ctl0_init_request_i, ctl0_sleep_request_i, ctl0_wakeup_enable_i;
	logic rx_ie_wr_i, tx_ie_wr_i, tx_ctl_wr_i, cfg_wr_i, cpu_int_mask_i;
	logic [3:0] rx_ie_data_i, rx_flag_clear_i, rx_flags_o;
	logic [2:0] tx_ie_data_i, tx_flag_clear_i, tx_abort_request_data_i, tx_buffer_select_data_i;
	logic [4:0] cfg_index_i;
	logic [7:0] cfg_data_i;
	logic can_tx_i, bus_idle_i, bus_activity_i, rx_fg_loaded_i, rx_overrun_i;
	logic [2:0] tx_buffer_empty_i, tx_aborted_i, tx_empty_flags_o;
	logic [2:0] tx_abort_request_o, tx_abort_ack_o, tx_buffer_select_o;
	logic [8:0] tx_err_cnt_i, rx_err_cnt_i;
	logic can_tx_pin_o, engine_stop_o, abort_o, init_request_o, init_ack_o, sleep_ack_o;
	logic [1:0] tx_state_field_o, rx_state_field_o;
	logic [`CFG_REGS*8-1:0] cfg_o;
	logic irq_wakeup_o, irq_error_o, irq_rx_o, irq_tx_o;
	int err_total = 0;
	int total_checks = 0;
	int aborts = 0;
	int n;
	logic [8:0] cnt_tab [6] = '{9'h05F, 9'h060, 9'h07F, 9'h080, 9'h0FF, 9'h100};
	logic [1:0] st_tab [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};

	can_init_ctrl DUT (.clk_i, .rst_n_i, .ctl0_wr_i, .ctl0_init_request_i, .ctl0_sleep_request_i,
		.ctl0_wakeup_enable_i, .rx_ie_wr_i, .rx_ie_data_i, .tx_ie_wr_i, .tx_ie_data_i, .rx_flag_clear_i,
		.tx_flag_clear_i, .tx_ctl_wr_i, .tx_abort_request_data_i, .tx_buffer_select_data_i, .cfg_wr_i,
		.cfg_index_i, .cfg_data_i, .cpu_int_mask_i, .can_tx_i, .bus_idle_i, .bus_activity_i,
		.rx_fg_loaded_i, .rx_overrun_i, .tx_buffer_empty_i, .tx_aborted_i, .tx_err_cnt_i, .rx_err_cnt_i,
		.can_tx_pin_o, .engine_stop_o, .abort_o, .init_request_o, .init_ack_o, .sleep_ack_o, .rx_flags_o,
		.tx_empty_flags_o, .tx_state_field_o, .rx_state_field_o, .tx_abort_request_o, .tx_abort_ack_o,
		.tx_buffer_select_o, .cfg_o, .irq_wakeup_o, .irq_error_o, .irq_rx_o, .irq_tx_o);
	can_bus_model PEER (.clk_i, .can_tx_o(can_tx_i), .bus_idle_o(bus_idle_i), .bus_activity_o(bus_activity_i),
		.rx_fg_loaded_o(rx_fg_loaded_i), .rx_overrun_o(rx_overrun_i), .tx_buffer_empty_o(tx_buffer_empty_i),
		.tx_aborted_o(tx_aborted_i), .tx_err_cnt_o(tx_err_cnt_i), .rx_err_cnt_o(rx_err_cnt_i));

	initial begin
		clk_i = 1'h0;
		forever #25 clk_i = ~clk_i;
	end
	always @(negedge clk_i) if (abort_o === 1'h1) aborts++;
	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (err_total == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t %s: saw %0h expected %0h", $time, m, seen, exp);
		end
	endtask
	task automatic settle(input int c);
		repeat (c) @(negedge clk_i);
	endtask
	// 0 ctl0, 1 rx enables, 2 tx enables, 3 rx clear, 4 tx clear, 5 tx control, other cfg
	task automatic wr(input int sel, input logic [7:0] d, input logic [4:0] idx);
		@(negedge clk_i);
		{ctl0_wakeup_enable_i, ctl0_sleep_request_i, ctl0_init_request_i} = d[2:0];
		rx_ie_data_i = d[3:0];
		tx_ie_data_i = d[2:0];
		{tx_buffer_select_data_i, tx_abort_request_data_i} = d[5:0];
		cfg_index_i = idx;
		cfg_data_i = d;
		case (sel)
		0: ctl0_wr_i = 1'h1;
		1: rx_ie_wr_i = 1'h1;
		2: tx_ie_wr_i = 1'h1;
		3: rx_flag_clear_i = d[3:0];
		4: tx_flag_clear_i = d[2:0];
		5: tx_ctl_wr_i = 1'h1;
		default: cfg_wr_i = 1'h1;
		endcase
		@(negedge clk_i);
		{ctl0_wr_i, rx_ie_wr_i, tx_ie_wr_i, tx_ctl_wr_i, cfg_wr_i} = 5'h00;
		rx_flag_clear_i = 4'h0;
		tx_flag_clear_i = 3'h0;
	endtask
	// counts rising edges until the selected flag reaches v: 0 init ack, other sleep ack
	task automatic wait_flag(input int sel, input logic v, output int c);
		c = 0;
		while (((sel == 0) ? init_ack_o : sleep_ack_o) !== v && c < 40) begin
			@(posedge clk_i);
			#1;
			c++;
		end
		if (c >= 40) begin
			chk(32'h0, 32'h1, "wait timeout");
			stop_test();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n_i = 1'h0;
		{ctl0_wr_i, ctl0_init_request_i, ctl0_sleep_request_i, ctl0_wakeup_enable_i} = 4'h0;
		{rx_ie_wr_i, tx_ie_wr_i, tx_ctl_wr_i, cfg_wr_i, cpu_int_mask_i} = 5'h00;
		{rx_ie_data_i, rx_flag_clear_i} = 8'h00;
		{tx_ie_data_i, tx_flag_clear_i, tx_abort_request_data_i, tx_buffer_select_data_i} = 12'h000;
		cfg_index_i = 5'h00;
		cfg_data_i = 8'h00;
		settle(10);
		rst_n_i = 1'h1;
		chk(can_tx_pin_o, 1, "pin reset");
		chk(tx_empty_flags_o, 7, "tx empty reset");
		chk({rx_flags_o, irq_tx_o, irq_rx_o}, 0, "flags reset");
		wr(1, 8'h0F, 0);
		wr(2, 8'h01, 0);
		settle(1);
		chk(irq_tx_o, 1, "tx irq on empty");
		PEER.levels(3'h6, 9'h000, 9'h000);
		wr(4, 8'h01, 0);
		chk(tx_empty_flags_o, 6, "tx flag clear");
		settle(1);
		chk(irq_tx_o, 0, "tx irq follows enabled flag only");
		PEER.levels(3'h7, 9'h000, 9'h000);
		settle(2);
		chk({tx_empty_flags_o, irq_tx_o}, 4'hF, "tx flag set again");
		PEER.pulse(6'h02);
		settle(1);
		chk({rx_flags_o[0], irq_rx_o}, 3, "rx full");
		cpu_int_mask_i = 1'h1;
		settle(1);
		chk(irq_rx_o, 0, "global mask");
		cpu_int_mask_i = 1'h0;
		wr(3, 8'h01, 0);
		chk(rx_flags_o[0], 0, "rx full cleared");
		PEER.pulse(6'h02);
		chk(rx_flags_o[0], 1, "rx full set by next message");
		PEER.pulse(6'h01);
		settle(1);
		chk({rx_flags_o[1], irq_error_o}, 3, "overrun");
		wr(3, 8'h03, 0);
		settle(1);
		chk(irq_error_o, 0, "error irq drops");
		for (int i = 0; i < 6; i++) begin
			PEER.levels(3'h7, cnt_tab[i], 9'h000);
			settle(3);
			chk(tx_state_field_o, st_tab[i], "tx state");
			chk(rx_flags_o[2], i > 0, "status change");
		end
		chk(irq_error_o, 1, "error irq on status");
		PEER.levels(3'h7, 9'h000, 9'h080);
		settle(3);
		chk(rx_state_field_o, 2, "rx state");
		wr(5, 8'h15, 0);
		chk({tx_buffer_select_o, tx_abort_request_o}, 6'h15, "tx control");
		PEER.pulse(6'h08);
		chk({tx_abort_ack_o, tx_abort_request_o}, 6'h0C, "abort done on buffer 0");
		wr(6, 8'hA5, 0);
		chk(cfg_o[7:0], 8'h00, "cfg locked outside init");
		wr(0, 8'h06, 0);
		wait_flag(1, 1'h1, n);
		PEER.pulse(6'h04);
		settle(1);
		chk({rx_flags_o[3], irq_wakeup_o}, 3, "wakeup");
		wr(0, 8'h07, 0); // asleep before the init request
		wait_flag(0, 1'h1, n);
		chk(n, `BUS_SYNC_STAGES + `CAN_SYNC_STAGES + `ACK_SYNC_STAGES + 1, "init entry delay");
		chk(n >= `BUS_SYNC_STAGES + `CAN_SYNC_STAGES, 1, "init entry minimum");
		chk({engine_stop_o, can_tx_pin_o, aborts[1:0]}, 4'hD, "init entered");
		chk({rx_flags_o, tx_abort_request_o, tx_abort_ack_o, tx_buffer_select_o}, 0, "defaults");
		chk({irq_wakeup_o, irq_error_o, irq_rx_o, tx_empty_flags_o}, 7, "irq defaults");
		wr(6, 8'h5A, 18);
		chk(cfg_o[151:144], 8'h5A, "cfg write in init");
		wr(0, 8'h00, 0);
		wait_flag(0, 1'h0, n);
		chk(n, `BUS_SYNC_STAGES + `CAN_SYNC_STAGES + `ACK_SYNC_STAGES + 1, "init leave delay");
		chk(engine_stop_o, 0, "engine restarts");
		PEER.pulse(6'h02);
		settle(1);
		chk({rx_flags_o[0], irq_rx_o}, 2, "enables back to default");
		PEER.frame(1'h1);
		settle(2);
		chk(can_tx_pin_o, 0, "pin follows engine");
		wr(0, 8'h01, 0);
		wr(0, 8'h00, 0);
		chk(init_request_o, 1, "early clear refused");
		wait_flag(0, 1'h1, n);
		chk({can_tx_pin_o, aborts[1:0]}, 6, "abort mid-frame, pin recessive");
		PEER.frame(1'h0);
		wr(0, 8'h00, 0);
		wait_flag(0, 1'h0, n);
		chk(init_request_o, 0, "clear after ack");
		stop_test();
	end
endmodule

// ==== can_init_pkg.sv ====
// types for the can init-mode and interrupt block
`include "can_init_cfg.svh"
package can_init_pkg;
	typedef enum logic [1:0] {
		RUN_ST   = 2'h0,
		ENTER_ST = 2'h1,
		INIT_ST  = 2'h3,
		LEAVE_ST = 2'h2
	} init_state_t;

	typedef struct packed {
		init_state_t                      fsm;
		logic                             init_request;
		logic                             init_ack;
		logic [`BUS_SYNC_STAGES-1:0]      bus_sync;
		logic [`CAN_SYNC_STAGES-1:0]      can_sync;
		logic [`ACK_SYNC_STAGES-1:0]      ack_sync;
		logic                             abort;
		logic                             sleep_request;
		logic                             sleep_ack;
		logic                             wakeup_enable;
		logic [3:0]                       rx_flags;
		logic [3:0]                       rx_ie;
		logic [2:0]                       tx_empty_flags;
		logic [2:0]                       tx_empty_ie;
		logic [2:0]                       tx_abort_request;
		logic [2:0]                       tx_abort_ack;
		logic [2:0]                       tx_buffer_select;
		logic [1:0]                       tx_state;
		logic [1:0]                       rx_state;
		logic                             can_tx;
		logic                             engine_stop;
		logic [3:0]                       irq;
		logic [`CFG_REGS-1:0][7:0]        cfg;
	} state_t;
endpackage
